// ### verilog/esb_pkg.sv
// Purpose: constants and types shared by the two-wire memory bus slave
// Assumes: 100 MHz mclk, bus pins sampled through two flip-flops
// Notes: offsets, field widths and default timing counts live here; address-word bit slices sit in the slave
//
// What this block does
// - address word: type, select, direction, msb first
// - select bits hard-wired to one, zero, zero
// - direction bit one reads, zero writes
// - matching address word acknowledged on ninth clock
// - mismatch: no acknowledge, release, back to idle
// - high then low address byte, each acknowledged
// - byte write acknowledged, stop launches timed write
// - more bytes mean page write, up to 32
// - page write increments only five offset bits
// - offset wraps within page, overwriting buffered bytes
// - stop after page write launches write, bus ignored
// - no acknowledge while write cycle busy
// - counter holds last address plus one
// - read shifts byte; nack and stop end read
// - counter wraps at array end or page end
// - counter cleared to zero at power-on
// - random read: dummy write, repeated start, read
// - master ack advances address and sends next byte
// - sequential read wraps to zero without pause
// - start, nine dummy clocks, start abandons command
// - reset sequence ignored while write cycle runs
// - start is data falling while clock high
// - stop is data rising while clock high
// - sample on clock rise, drive after fall
// - write-protect high during address or data bytes blocks the array write
package esb_pkg;
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int WC_TIME_MS = 5;                       // internal_write_cycle_time
   localparam int WC_CYCLES_DFLT = WC_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int BYTE_BITS = 8;
   localparam int ADDR_W = 16;                          // high_address_byte + low_address_byte
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_OFS_W = 5;                       // page_offset_bits
   localparam int SEL_W = 3;
   localparam int TYPE_W = 4;
   localparam logic [SEL_W-1:0] SEL_CODE = 3'h4;        // select_bit_two=1, one=0, zero=0
   localparam logic [3:0] ACK_CLOCK = 4'h8;             // bit count of the ninth clock
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = ADDR_W + BYTE_BITS;
   localparam logic [5:0] DRAIN_END = 6'h20;            // one past the last page slot

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_DEV   = 6'h02,
      ST_ADH   = 6'h04,
      ST_ADL   = 6'h08,
      ST_WDATA = 6'h10,
      ST_RDATA = 6'h20
   } esb_state_t;
endpackage : esb_pkg

// ### verilog/esb_slave.sv
// Purpose: two-wire bus slave front end of a serial memory with page buffer
// Assumes: scl, sda and wp arrive asynchronously; array sits outside the block
// Notes: write bytes leave through a FIFO to the array port during the busy time
`timescale 1ns/10ps

// simple FIFO, valid/ready on both sides
module esb_fifo #(
   parameter int W = 24,
   parameter int D = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   import esb_pkg::*;
   localparam int PW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0] count;
   } esb_fifo_st_t;

   esb_fifo_st_t r;
   esb_fifo_st_t next_r;
   logic push;
   logic pop;

   // honest full and empty from the fill count
   assign in_ready = (r.count != (PW+1)'(D));
   assign out_valid = (r.count != '0);
   assign out_data = r.mem[r.rptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      next_r = r;
      if (push) begin
         next_r.mem[r.wptr] = in_data;
         next_r.wptr = (r.wptr == PW'(D-1)) ? '0 : r.wptr + 1'b1;
      end
      if (pop) begin
         next_r.rptr = (r.rptr == PW'(D-1)) ? '0 : r.rptr + 1'b1;
      end
      next_r.count = r.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : esb_fifo

// bus slave: start/stop detect, byte engine, page buffer, write timer
module esb_slave #(
   parameter logic [3:0] DEV_TYPE = 4'h6,              // arbitrary device-type value
   parameter int WC_CYCLES = esb_pkg::WC_CYCLES_DFLT
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic wp_i,
   output logic [esb_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [esb_pkg::BYTE_BITS-1:0] rd_data,
   output logic arr_valid,
   input wire logic arr_ready,
   output logic [esb_pkg::ADDR_W-1:0] arr_addr,
   output logic [esb_pkg::BYTE_BITS-1:0] arr_data,
   output logic busy
);
   import esb_pkg::*;

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic wp_m;
      logic wp_s;
      esb_state_t st;
      logic [3:0] bitcnt;
      logic [BYTE_BITS-1:0] shreg;
      logic [BYTE_BITS-1:0] tx;
      logic oe;
      logic ack;
      logic [BYTE_BITS-1:0] hi;
      logic [ADDR_W-1:0] addr;
      logic [PAGE_BYTES-1:0][BYTE_BITS-1:0] pbuf;
      logic [PAGE_BYTES-1:0] pvalid;
      logic wp_hit;
      logic busy;
      logic [31:0] wc_cnt;
      logic [5:0] drain;
   } esb_st_t;

   esb_st_t r;
   esb_st_t next_r;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [BYTE_BITS-1:0] byte_in;
   logic byte_done;
   logic f_valid;
   logic f_ready;
   logic [FIFO_W-1:0] f_data;
   logic [FIFO_W-1:0] arr_word;
   logic [PAGE_OFS_W-1:0] didx;

   // edges from the second and third sync stages only
   assign scl_rise = r.scl_s && !r.scl_p;
   assign scl_fall = !r.scl_s && r.scl_p;
   assign start_c = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
   assign stop_c = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;
   assign byte_in = {r.shreg[BYTE_BITS-2:0], r.sda_s};
   assign byte_done = scl_rise && (r.bitcnt == LAST_BIT) && (r.st != ST_IDLE)
                      && (r.st != ST_RDATA);

   // page drain toward the array FIFO
   assign didx = r.drain[PAGE_OFS_W-1:0];
   assign f_valid = r.busy && (r.drain != DRAIN_END) && r.pvalid[didx];
   assign f_data = {r.addr[ADDR_W-1:PAGE_OFS_W], didx, r.pbuf[didx]};

   // open-drain data pin: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = r.oe;
   assign busy = r.busy;
   assign rd_addr = r.addr;
   assign arr_addr = arr_word[FIFO_W-1:BYTE_BITS];
   assign arr_data = arr_word[BYTE_BITS-1:0];

   // next-state logic of the whole slave
   always_comb begin
      next_r = r;
      next_r.scl_m = scl_i;
      next_r.scl_s = r.scl_m;
      next_r.scl_p = r.scl_s;
      next_r.sda_m = sda_i;
      next_r.sda_s = r.sda_m;
      next_r.sda_p = r.sda_s;
      next_r.wp_m = wp_i;
      next_r.wp_s = r.wp_m;

      // write cycle timer and drain run regardless of the bus
      if (r.busy) begin
         if (r.wc_cnt == '0) begin
            next_r.busy = 1'b0;
         end else begin
            next_r.wc_cnt = r.wc_cnt - 32'h1;
         end
         if (r.drain != DRAIN_END && (!r.pvalid[didx] || f_ready)) begin
            next_r.drain = r.drain + 6'h1;
         end
      end

      if (r.busy) begin
         // bus input ignored; reset sequence has no effect here
         next_r.st = ST_IDLE;
         next_r.oe = 1'b0;
         next_r.ack = 1'b0;
      end else if (start_c) begin
         // any start, repeated or not, abandons a partial command
         next_r.st = ST_DEV;
         next_r.bitcnt = '0;
         next_r.oe = 1'b0;
         next_r.ack = 1'b0;
         next_r.wp_hit = 1'b0;
         next_r.pvalid = '0;
      end else if (stop_c) begin
         next_r.st = ST_IDLE;
         next_r.oe = 1'b0;
         next_r.ack = 1'b0;
         if (r.st == ST_WDATA && r.pvalid != '0 && !r.wp_hit) begin
            next_r.busy = 1'b1;
            next_r.wc_cnt = 32'(WC_CYCLES - 1);
            next_r.drain = '0;
         end
      end else begin
         // protection holds if wp is seen high in the address or data bytes of the write
         if (r.wp_s && (r.st == ST_ADH || r.st == ST_ADL || r.st == ST_WDATA)) begin
            next_r.wp_hit = 1'b1;
         end
         if (scl_rise && r.st != ST_IDLE) begin
            // data sampled on the clock rise
            if (r.bitcnt == ACK_CLOCK) begin
               next_r.bitcnt = '0;
               if (r.ack) begin
                  next_r.ack = 1'b0;
               end else if (r.st == ST_RDATA) begin
                  // counter advances past each byte sent, wrapping at the top
                  next_r.addr = r.addr + 16'h1;
                  if (r.sda_s) begin
                     next_r.st = ST_IDLE;
                  end
               end
            end else if (r.st != ST_RDATA) begin
               next_r.shreg = byte_in;
               next_r.bitcnt = r.bitcnt + 4'h1;
            end else begin
               next_r.bitcnt = r.bitcnt + 4'h1;
            end
         end
         if (byte_done) begin
            next_r.ack = 1'b1;
            unique case (r.st)
               ST_DEV: begin
                  if (byte_in[7:4] != DEV_TYPE || byte_in[3:1] != SEL_CODE) begin
                     next_r.st = ST_IDLE;
                     next_r.ack = 1'b0;
                  end else if (byte_in[0]) begin
                     next_r.st = ST_RDATA;
                  end else begin
                     next_r.st = ST_ADH;
                  end
               end
               ST_ADH: begin
                  next_r.hi = byte_in;
                  next_r.st = ST_ADL;
               end
               ST_ADL: begin
                  next_r.addr = {r.hi, byte_in};
                  next_r.st = ST_WDATA;
                  next_r.pvalid = '0;
               end
               ST_WDATA: begin
                  // later bytes to the same slot overwrite the earlier ones
                  next_r.pbuf[r.addr[PAGE_OFS_W-1:0]] = byte_in;
                  next_r.pvalid[r.addr[PAGE_OFS_W-1:0]] = 1'b1;
                  next_r.addr[PAGE_OFS_W-1:0] = r.addr[PAGE_OFS_W-1:0] + 5'h1;
               end
               default: begin
                  next_r.st = ST_IDLE;
                  next_r.ack = 1'b0;
               end
            endcase
         end
         if (scl_fall) begin
            // output changes only after the clock fall
            if (r.bitcnt == ACK_CLOCK) begin
               next_r.oe = r.ack;
            end else if (r.st == ST_RDATA && r.bitcnt == 4'h0) begin
               next_r.tx = rd_data;
               next_r.oe = !rd_data[BYTE_BITS-1];
            end else if (r.st == ST_RDATA) begin
               next_r.tx = {r.tx[BYTE_BITS-2:0], 1'b0};
               next_r.oe = !r.tx[BYTE_BITS-2];
            end else begin
               next_r.oe = 1'b0;
            end
         end
      end
   end

   // one register for the whole state; counter clears to zero at power-on
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= ST_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // buffered path to the array; array stalls through arr_ready
   esb_fifo #(
      .W(FIFO_W),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(f_valid),
      .in_ready(f_ready),
      .in_data(f_data),
      .out_valid(arr_valid),
      .out_ready(arr_ready),
      .out_data(arr_word)
   );

   // checks beside the logic
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_dev_match;
      byte_done && r.st == ST_DEV && byte_in[7:4] == DEV_TYPE && byte_in[3:1] == SEL_CODE;
   endsequence

   sequence s_dev_miss;
      byte_done && r.st == ST_DEV && (byte_in[7:4] != DEV_TYPE || byte_in[3:1] != SEL_CODE);
   endsequence

   sequence s_launch;
      !r.busy && stop_c && r.st == ST_WDATA && r.pvalid != '0 && !r.wp_hit;
   endsequence

   AST_DEV_ACK: assert property (s_dev_match |=> r.ack ##0 r.bitcnt == ACK_CLOCK)
      else $error("matching address word not acknowledged");
   AST_DEV_MISS: assert property (s_dev_miss |=> r.st == ST_IDLE && !r.ack && !sda_oe)
      else $error("mismatched address word not released");
   AST_BUSY_QUIET: assert property (r.busy |=> !sda_oe)
      else $error("bus driven during write cycle");
   AST_LAUNCH: assert property (s_launch |=> busy && r.wc_cnt == 32'(WC_CYCLES - 1))
      else $error("stop after write data did not launch write cycle");
   AST_WC_END: assert property (busy && r.wc_cnt == '0 |=> !busy)
      else $error("write cycle length wrong");
   AST_WC_HOLD: assert property (busy && r.wc_cnt != '0 |=> busy && r.wc_cnt == $past(r.wc_cnt) - 32'h1)
      else $error("write cycle ended early");
   AST_WP_BLOCK: assert property (!r.busy && stop_c && r.wp_hit |=> !busy)
      else $error("protected write launched");
   AST_PAGE_OFS: assert property (byte_done && r.st == ST_WDATA |=>
      r.addr[ADDR_W-1:PAGE_OFS_W] == $past(r.addr[ADDR_W-1:PAGE_OFS_W])
      && r.addr[PAGE_OFS_W-1:0] == $past(r.addr[PAGE_OFS_W-1:0]) + 5'h1)
      else $error("page offset did not step within page");
   AST_READ_NEXT: assert property (!r.busy && !start_c && !stop_c && scl_rise && r.st == ST_RDATA
      && r.bitcnt == ACK_CLOCK && !r.ack |=> r.addr == $past(r.addr) + 16'h1)
      else $error("read address did not advance");
   AST_START: assert property (!r.busy && start_c |=> r.st == ST_DEV && r.bitcnt == '0 ##1 !sda_oe)
      else $error("start did not restart the command");
   AST_DRIVE_FALL: assert property ($rose(sda_oe) |-> $past(scl_fall))
      else $error("data driven outside a clock fall");
endmodule : esb_slave

// ### test/esb_bus_master.sv
// Purpose: behavioural two-wire bus master driving scl and pulling sda low
// Assumes: called at falling mclk edges; 4 mclk a phase gives an 80 ns scl
// Notes: scl stands high between frames; sda is open drain with a pull-up
`timescale 1ns/10ps
module esb_bus_master (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   // idle bus: scl high, sda released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // wait n falling edges; every change happens there
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick
   // start or repeated start; sda moves one mclk after scl fell
   task automatic start();
      tick(1);
      sda_pull = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_pull = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask : start
   // stop: sda rises while scl high
   task automatic stop();
      tick(1);
      sda_pull = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_pull = 1'b0;
      tick(4);
   endtask : stop
   // one clock: set data in the low phase, sample late in the high phase
   task automatic bit_io(input logic b, output logic s);
      tick(1);
      sda_pull = ~b;
      tick(3);
      scl = 1'b1;
      tick(4);
      s = sda;
      scl = 1'b0;
   endtask : bit_io
   // byte out msb first, then the ninth-clock level (low means ack)
   task automatic wbyte(input logic [7:0] b, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, nack);
   endtask : wbyte
   // byte in msb first, then master ack (low) or nack (high)
   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(nack, s);
   endtask : rbyte
endmodule : esb_bus_master

// ### test/esb_slave_tb.sv
// Purpose: self-checking bench for the two-wire memory bus slave
// Assumes: 100 MHz mclk, master model on the bus, byte array modelled here
// Notes: write cycle shortened to WC cycles; array port stalled in the page test
`timescale 1ns/10ps
module esb_slave_tb;
   import esb_pkg::*;
   localparam int WC = 400;
   localparam logic [3:0] DT = 4'h9;  // arbitrary device-type value
   logic mclk, rst_n, wp_i, arr_ready, arr_valid, busy, sda_o, sda_oe, scl, sda_pull, n;
   logic hold, slow, tog = 1'b0;
   logic [ADDR_W-1:0] rd_addr, arr_addr;
   logic [7:0] rd_data, arr_data, b;
   logic [7:0] mem [0:65535];
   int n_mismatch = 0, comparisons = 0, bcnt = 0, blen = 0;
   wire sda_w = !(sda_pull || (sda_oe && !sda_o));
   esb_slave #(.DEV_TYPE(DT), .WC_CYCLES(WC)) dut (.mclk(mclk), .rst_n(rst_n), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .rd_addr(rd_addr),
      .rd_data(rd_data), .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_addr(arr_addr),
      .arr_data(arr_data), .busy(busy));
   esb_bus_master m (.mclk(mclk), .sda(sda_w), .scl(scl), .sda_pull(sda_pull));
   // array read port
   assign rd_data = mem[rd_addr];
   // array write port: full stall on hold, every other cycle refused when slow
   assign arr_ready = !(hold || (slow && tog));
   always @(negedge mclk) tog <= ~tog;
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] + a[15:8] * 8'h03 + 8'h01;
   endfunction : pat
   function automatic logic [7:0] aw(input logic rw);
      return {DT, SEL_CODE, rw};
   endfunction : aw
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // array write port and length of each busy pulse
   always @(posedge mclk) begin
      if (arr_valid && arr_ready)
         mem[arr_addr] <= arr_data;
      if (busy === 1'b1)
         bcnt <= bcnt + 1;
      else if (bcnt != 0) begin
         blen <= bcnt;
         bcnt <= 0;
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_idle();
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) m.tick(1);
      m.tick(2);
   endtask : wait_idle
   task automatic t_reset();
      chk("busy", 16'h0, busy);
      chk("sda_oe", 16'h0, sda_oe);
      chk("arr_valid", 16'h0, arr_valid);
      chk("rd_addr", 16'h0, rd_addr);
      chk("sda_o", 16'h0, sda_o);
   endtask : t_reset
   task automatic t_mismatch();
      for (int k = 0; k < 4; k++) begin
         m.start();
         m.wbyte(k == 0 ? {4'h3, SEL_CODE, 1'b0} : {DT, SEL_CODE ^ (3'h1 << (k - 1)), 1'b0}, n);
         chk("ack bad word", 16'h1, n);
         m.stop();
      end
   endtask : t_mismatch
   task automatic t_byte_write();
      m.start();
      m.wbyte(aw(1'b0), n);
      chk("ack addr", 16'h0, n);
      m.wbyte(8'h12, n);
      chk("ack hi", 16'h0, n);
      m.wbyte(8'h34, n);
      chk("ack lo", 16'h0, n);
      m.wbyte(8'h5a, n);
      chk("ack data", 16'h0, n);
      m.stop();
      m.tick(2);
      chk("busy", 16'h1, busy);
      m.start();
      m.wbyte(aw(1'b0), n);
      chk("poll busy", 16'h1, n);
      m.start();
      m.wbyte(8'hff, n);
      m.start();
      m.stop();
      wait_idle();
      chk("busy length", WC[15:0], blen[15:0]);
      chk("array byte", 16'h5a, mem[16'h1234]);
      chk("rd_addr", 16'h1235, rd_addr);
      m.start();
      m.wbyte(aw(1'b0), n);
      chk("poll done", 16'h0, n);
      m.stop();
   endtask : t_byte_write
   task automatic t_page();
      m.start();
      m.wbyte(aw(1'b0), n);
      m.wbyte(8'h01, n);
      m.wbyte(8'h5e, n);
      for (int k = 0; k < 34; k++) begin
         m.wbyte(8'h80 + k[7:0], n);
         chk("ack page", 16'h0, n);
      end
      hold = 1'b1;
      slow = 1'b1;
      m.stop();
      m.tick(60);
      chk("arr_valid stalled", 16'h1, arr_valid);
      hold = 1'b0;
      wait_idle();
      slow = 1'b0;
      for (int s = 0; s < 32; s++) begin
         chk("page slot", 16'h82 + s[15:0], mem[16'h0140 + s[15:0]]);
      end
      chk("next page", pat(16'h0160), mem[16'h0160]);
      chk("rd_addr", 16'h0140, rd_addr);
   endtask : t_page
   task automatic t_reads();
      m.start();
      m.wbyte(aw(1'b0), n);
      m.wbyte(8'hff, n);
      m.wbyte(8'hfe, n);
      m.start();
      m.wbyte(aw(1'b1), n);
      chk("ack read", 16'h0, n);
      m.rbyte(1'b0, b);
      chk("read fffe", pat(16'hfffe), b);
      m.rbyte(1'b0, b);
      chk("read ffff", pat(16'hffff), b);
      m.rbyte(1'b1, b);
      chk("read wrap", pat(16'h0000), b);
      m.stop();
      chk("rd_addr", 16'h0001, rd_addr);
      m.start();
      m.wbyte(aw(1'b1), n);
      m.rbyte(1'b1, b);
      m.stop();
      chk("current read", pat(16'h0001), b);
   endtask : t_reads
   task automatic t_protect();
      wp_i = 1'b1;
      m.start();
      m.wbyte(aw(1'b0), n);
      m.wbyte(8'h00, n);
      m.wbyte(8'h10, n);
      m.wbyte(8'h77, n);
      m.stop();
      m.tick(20);
      chk("busy protected", 16'h0, busy);
      chk("array protected", pat(16'h0010), mem[16'h0010]);
      wp_i = 1'b0;
   endtask : t_protect
   task automatic t_soft_reset();
      m.start();
      m.wbyte(aw(1'b0), n);
      m.wbyte(8'h00, n);
      m.start();
      m.wbyte(8'hff, n);  // nine clocks with sda released
      m.start();
      m.wbyte(aw(1'b1), n);
      chk("ack after reset", 16'h0, n);
      m.rbyte(1'b1, b);
      m.stop();
      m.tick(4);
      chk("busy after reset", 16'h0, busy);
      chk("read after reset", pat(16'h0011), b);
   endtask : t_soft_reset
   task automatic t_power_cycle();
      chk("rd_addr before reset", 16'h0012, rd_addr);
      rst_n = 1'b0;
      m.tick(8);
      rst_n = 1'b1;
      t_reset();
      m.tick(3);
      m.start();
      m.wbyte(aw(1'b1), n);
      chk("ack after power-on", 16'h0, n);
      m.rbyte(1'b1, b);
      m.stop();
      chk("read after power-on", pat(16'h0000), b);
   endtask : t_power_cycle
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   // main sequence: reset, then each scenario in turn
   initial begin
      rst_n = 1'b0;
      wp_i = 1'b0;
      hold = 1'b0;
      slow = 1'b0;
      for (int i = 0; i < 65536; i++) mem[i] = pat(i[15:0]);
      m.tick(8);
      rst_n = 1'b1;
      t_reset();
      m.tick(3);
      t_mismatch();
      t_byte_write();
      t_page();
      t_reads();
      t_protect();
      t_soft_reset();
      t_power_cycle();
      report_and_stop();
   end
   // watchdog against a hung handshake
   initial begin
      m.tick(30000);
      n_mismatch++;
      $display("MISMATCH watchdog expected finish seen timeout");
      report_and_stop();
   end
endmodule : esb_slave_tb
